// ===== pmu_seq_pkg.sv
// Constants for the power sequencer and charger timing block.
// Assumes a 20 MHz bus clock; all timers advance on a derived 1 ms tick.
package pmu_seq_pkg;
  // Clock and derived tick
  localparam int CLK_PERIOD_NS   = 50;
  localparam int TICK_PERIOD_NS  = 1_000_000;
  localparam int TICK_CYCLES     = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int MS_PER_HOUR     = 3_600_000;
  // Times in milliseconds
  localparam int ADAPTER_DG_MS   = 30;
  localparam int PREQUAL_DG_MS   = 210;
  localparam int EOC_DG_MS       = 210;
  localparam int HOLD_SHORT_MS   = 35;
  localparam int HOLD_LONG_MS    = 350;
  // Charge timer limits in hours
  localparam int PRE_HOURS_A     = 1;
  localparam int PRE_HOURS_B     = 2;
  localparam int CC_HOURS_SHORT  = 5;
  localparam int CC_HOURS_LONG   = 8;
  // Charger thresholds
  localparam logic [12:0] VTERM_MV      = 13'd4200;
  localparam logic [12:0] RESTART_DROP  = 13'd100;
  localparam logic [10:0] EOC_FIXED_MA  = 11'd50;
  localparam int          EOC_TENTH_DIV = 10;
  // Serial slave address
  localparam logic [6:0]  SLAVE_ADDR    = 7'h7E;
  // Register byte offsets
  localparam logic [7:0] CHG_CTRL_OFS   = 8'h00;
  localparam logic [7:0] CHG_ICHG_OFS   = 8'h04;
  localparam logic [7:0] MISC_CTRL_OFS  = 8'h08;
  localparam logic [7:0] STATE_OFS      = 8'h0C;
  localparam logic [7:0] IRQ_STAT_OFS   = 8'h10;
  localparam logic [7:0] IRQ_MASK_OFS   = 8'h14;
  localparam logic [7:0] ADDR_ID_OFS    = 8'h18;
  // CHG_CTRL fields
  localparam int CC_EN_BIT       = 0;
  localparam int CC_EOC_EN_BIT   = 1;
  localparam int CC_TENTH_BIT    = 2;
  localparam int CC_LONG_BIT     = 3;
  localparam int CC_PRE_LSB      = 4;
  localparam logic [5:0]  CHG_CTRL_RST  = 6'h03;
  localparam logic [10:0] ICHG_RST      = 11'd400;
  // MISC_CTRL field
  localparam int MISC_HOLD_BIT   = 0;
  // Interrupt status bits
  localparam int IRQ_W           = 5;
  localparam int EV_OVERTEMP     = 0;
  localparam int EV_TOUT_PRE     = 1;
  localparam int EV_TOUT_FULL    = 2;
  localparam int EV_EOC          = 3;
  localparam int EV_ADAPTER      = 4;
  // Pin indices in the synchroniser
  localparam int PIN_W           = 5;
  localparam int PIN_KEY         = 0;
  localparam int PIN_HF          = 1;
  localparam int PIN_ADAPTER     = 2;
  localparam int PIN_HOLD        = 3;
  localparam int PIN_HOT         = 4;

  typedef enum logic [2:0] {
    PWR_OFF, PWR_UP, POWER_KEY_INPUT, PWR_RELEASE, PWR_DOWN
  } pwr_state_type;

  typedef enum logic [2:0] {
    CHG_IDLE, CHG_PRE, CHG_FULL, CHG_DONE, CHG_FAULT
  } chg_state_type;
endpackage

// ===== pmu_seq.sv
// Power-up/power-down sequencer and charger timing logic with AHB-Lite registers.
// Assumes asynchronous pins from the analog side and ADC codes on the bus clock.
//
// Function
// - Adapter counted valid only after adapter-above-battery persists 30 ms.
// - Pre-charge to full-rate only after qualification persists 210 ms.
// - Safety timer: full-rate 5 or 8 hours, restarted at full-rate entry; pre-charge 1, 2 or disabled.
// - End of charge declared only after its condition persists 210 ms.
// - Tenth option: end of charge at 10 percent of full-rate current.
// - After end of charge, restart when battery drops 100 mV below 4.2 V.
// - Adapter detect starts power-up on its rising edge only.
// - Hands-free input starts power-up by level, standby and reset states.
// - Power key starts power-up while its level is active.
// - Once hold asserted, power key no longer controls power.
// - Key echo is the undebounced inverse of power key while regulator three on.
// - Hold release waits 35 ms or 350 ms, by select bit, before power-down.
// - Serial port answers slave address 7E hex; no serial port here, the address ID register only reads back 7E hex.
// - Power-down end restores control registers except charger controls.
// - Over-temperature sets flag and starts power-down.
//
// The AHB-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module pmu_seq
  import pmu_seq_pkg::*;
#(
  parameter int TICK_CYC  = pmu_seq_pkg::TICK_CYCLES,
  parameter int MS_HOUR   = pmu_seq_pkg::MS_PER_HOUR
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        power_key_input,
  input  wire logic        handsfree_wake_input,
  input  wire logic        adapter_detect_input,
  input  wire logic        power_hold_input,
  input  wire logic        overtemp_input,
  input  wire logic        prequal_ok_input,
  input  wire logic [10:0] charge_current_ma,
  input  wire logic [12:0] battery_mv,
  output logic             power_key_echo_n,
  output logic             regulator_three,
  output logic             charge_enable,
  output logic             fullrate_mode,
  output logic             irq
);
  import pmu_seq_pkg::*;

  localparam int TW = $clog2(TICK_CYC + 1);

  // Pin synchronisers
  logic [PIN_W-1:0] s1_q, s2_q, s3_q, pin_q, pin_d;

  always_comb begin
    pin_d = pin_q;
    for (int i = 0; i < PIN_W; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        pin_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      pin_q <= '0;
    end else if (ce) begin
      s1_q  <= {overtemp_input, power_hold_input, adapter_detect_input,
                handsfree_wake_input, power_key_input};
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      pin_q <= pin_d;
    end
  end

  // Millisecond tick
  logic [TW-1:0] tick_cnt_q, tick_cnt_d;
  logic          tick;

  always_comb begin
    tick       = (tick_cnt_q == TW'(TICK_CYC - 1));
    tick_cnt_d = tick ? '0 : tick_cnt_q + TW'(1);
  end

  // Registers and state declared ahead of their users
  pwr_state_type      pwr_q, pwr_d;
  chg_state_type      chg_q, chg_d;
  logic [5:0]         chg_ctrl_q, chg_ctrl_d;
  logic [10:0]        ichg_q, ichg_d;
  logic               hold_sel_q, hold_sel_d;
  logic [IRQ_W-1:0]   irq_stat_q, irq_stat_d, irq_mask_q, irq_mask_d, ev;
  logic [2:0]         trig_q, trig_d;
  logic [8:0]         rel_cnt_q, rel_cnt_d;
  logic [24:0]        chg_tmr_q, chg_tmr_d;

  // Deglitch timers: adapter ok, pre-charge qualification, end of charge
  logic [8:0] dg_cnt_q [3];
  logic [8:0] dg_cnt_d [3];
  logic [2:0] dg_cond, dg_done;
  logic [8:0] dg_len [3];
  logic [14:0] cur_x10;

  always_comb begin
    dg_len[0] = 9'(ADAPTER_DG_MS);
    dg_len[1] = 9'(PREQUAL_DG_MS);
    dg_len[2] = 9'(EOC_DG_MS);
    cur_x10   = 15'(charge_current_ma) * 15'(EOC_TENTH_DIV);
    dg_cond[0] = pin_q[PIN_ADAPTER];
    dg_cond[1] = prequal_ok_input && (chg_q == CHG_PRE);
    if (chg_ctrl_q[CC_TENTH_BIT]) begin
      dg_cond[2] = (chg_q == CHG_FULL) && (cur_x10 <= 15'(ichg_q));
    end else begin
      dg_cond[2] = (chg_q == CHG_FULL) && (charge_current_ma <= EOC_FIXED_MA);
    end
    for (int i = 0; i < 3; i++) begin
      dg_done[i] = (dg_cnt_q[i] >= dg_len[i]);
      if (!dg_cond[i]) begin
        dg_cnt_d[i] = '0;
      end else if (tick && !dg_done[i]) begin
        dg_cnt_d[i] = dg_cnt_q[i] + 9'd1;
      end else begin
        dg_cnt_d[i] = dg_cnt_q[i];
      end
    end
  end

  logic adapter_ok, adapter_ok_q, adapter_ok_d, adapter_pin_q;
  assign adapter_ok = dg_done[0];

  // Power sequencer
  logic [8:0] rel_len;

  always_comb begin
    pwr_d     = pwr_q;
    trig_d    = trig_q;
    rel_cnt_d = rel_cnt_q;
    ev        = '0;
    rel_len   = hold_sel_q ? 9'(HOLD_LONG_MS) : 9'(HOLD_SHORT_MS);
    case (pwr_q)
      PWR_OFF: begin
        if (pin_q[PIN_KEY] || pin_q[PIN_HF] ||
            (pin_q[PIN_ADAPTER] && !adapter_pin_q)) begin
          pwr_d  = PWR_UP;
          trig_d = {pin_q[PIN_KEY], pin_q[PIN_HF],
                    pin_q[PIN_ADAPTER] && !adapter_pin_q};
        end
      end
      PWR_UP: begin
        if (pin_q[PIN_HOLD]) begin
          pwr_d = POWER_KEY_INPUT;
        end else if (!((trig_q[2] && pin_q[PIN_KEY]) || (trig_q[1] && pin_q[PIN_HF]) ||
                       (trig_q[0] && pin_q[PIN_ADAPTER]))) begin
          pwr_d = PWR_DOWN;
        end
      end
      POWER_KEY_INPUT: begin
        if (!pin_q[PIN_HOLD]) begin
          pwr_d     = PWR_RELEASE;
          rel_cnt_d = '0;
        end
      end
      PWR_RELEASE: begin
        if (pin_q[PIN_HOLD]) begin
          pwr_d = POWER_KEY_INPUT;
        end else if (rel_cnt_q >= rel_len) begin
          pwr_d = PWR_DOWN;
        end else if (tick) begin
          rel_cnt_d = rel_cnt_q + 9'd1;
        end
      end
      default: pwr_d = PWR_OFF;
    endcase
    if (pin_q[PIN_HOT] && pwr_q != PWR_OFF && pwr_q != PWR_DOWN) begin
      pwr_d           = PWR_DOWN;
    end
    ev[EV_OVERTEMP] = pin_q[PIN_HOT];
  end

  // Charger sequencer
  logic [24:0] pre_lim, cc_lim;
  logic        pre_on;

  always_comb begin
    chg_d     = chg_q;
    chg_tmr_d = (tick && (chg_q == CHG_PRE || chg_q == CHG_FULL)) ? chg_tmr_q + 25'd1
                                                                   : chg_tmr_q;
    pre_on    = (chg_ctrl_q[CC_PRE_LSB+1:CC_PRE_LSB] != 2'd0);
    pre_lim   = (chg_ctrl_q[CC_PRE_LSB+1:CC_PRE_LSB] == 2'd2) ? 25'(PRE_HOURS_B * MS_HOUR)
                                                               : 25'(PRE_HOURS_A * MS_HOUR);
    cc_lim    = chg_ctrl_q[CC_LONG_BIT] ? 25'(CC_HOURS_LONG * MS_HOUR)
                                        : 25'(CC_HOURS_SHORT * MS_HOUR);
    case (chg_q)
      CHG_IDLE: begin
        chg_d     = CHG_PRE;
        chg_tmr_d = '0;
      end
      CHG_PRE: begin
        if (dg_done[1]) begin
          chg_d     = CHG_FULL;
          chg_tmr_d = '0;
        end else if (pre_on && chg_tmr_q >= pre_lim) begin
          chg_d = CHG_FAULT;
        end
      end
      CHG_FULL: begin
        if (chg_ctrl_q[CC_EOC_EN_BIT] && dg_done[2]) begin
          chg_d = CHG_DONE;
        end else if (chg_tmr_q >= cc_lim) begin
          chg_d = CHG_FAULT;
        end
      end
      CHG_DONE: begin
        if (battery_mv <= VTERM_MV - RESTART_DROP) begin
          chg_d     = CHG_FULL;
          chg_tmr_d = '0;
        end
      end
      default: chg_d = chg_q;
    endcase
    if (!chg_ctrl_q[CC_EN_BIT] || !adapter_ok) begin
      chg_d = CHG_IDLE;
    end
  end

  always_comb begin
    adapter_ok_d = adapter_ok;
  end

  // AHB-Lite slave, zero wait states
  logic       dph_wr_q, dph_wr_d;
  logic [7:0] dph_addr_q, dph_addr_d;
  logic [31:0] rd_d;
  logic       acc;

  always_comb begin
    acc        = hsel && htrans[1] && hready;
    dph_wr_d   = acc && hwrite;
    dph_addr_d = acc ? haddr[7:0] : dph_addr_q;
    rd_d       = hrdata;
    if (acc && !hwrite) begin
      if (haddr[7:0] == CHG_CTRL_OFS) begin
        rd_d = {26'h000_0000, chg_ctrl_q};
      end else if (haddr[7:0] == CHG_ICHG_OFS) begin
        rd_d = {21'h00_0000, ichg_q};
      end else if (haddr[7:0] == MISC_CTRL_OFS) begin
        rd_d = {31'h0000_0000, hold_sel_q};
      end else if (haddr[7:0] == STATE_OFS) begin
        rd_d = {17'h0_0000, pin_q, adapter_ok, chg_q, trig_q, pwr_q};
      end else if (haddr[7:0] == IRQ_STAT_OFS) begin
        rd_d = {27'h000_0000, irq_stat_q};
      end else if (haddr[7:0] == IRQ_MASK_OFS) begin
        rd_d = {27'h000_0000, irq_mask_q};
      end else if (haddr[7:0] == ADDR_ID_OFS) begin
        rd_d = {25'h000_0000, SLAVE_ADDR};
      end else begin
        rd_d = 32'h0000_0000;
      end
    end
  end

  // Register file; set wins over write-one-to-clear
  always_comb begin
    chg_ctrl_d = chg_ctrl_q;
    ichg_d     = ichg_q;
    hold_sel_d = hold_sel_q;
    irq_mask_d = irq_mask_q;
    irq_stat_d = irq_stat_q;
    if (dph_wr_q) begin
      if (dph_addr_q == CHG_CTRL_OFS) begin
        chg_ctrl_d = hwdata[5:0];
      end else if (dph_addr_q == CHG_ICHG_OFS) begin
        ichg_d = hwdata[10:0];
      end else if (dph_addr_q == MISC_CTRL_OFS) begin
        hold_sel_d = hwdata[MISC_HOLD_BIT];
      end else if (dph_addr_q == IRQ_STAT_OFS) begin
        irq_stat_d = irq_stat_q & ~hwdata[IRQ_W-1:0];
      end else if (dph_addr_q == IRQ_MASK_OFS) begin
        irq_mask_d = hwdata[IRQ_W-1:0];
      end
    end
    if (pwr_q == PWR_DOWN) begin
      hold_sel_d = 1'b0;
      irq_mask_d = '0;
    end
    irq_stat_d[EV_OVERTEMP]  = irq_stat_d[EV_OVERTEMP] | ev[EV_OVERTEMP];
    irq_stat_d[EV_TOUT_PRE]  = irq_stat_d[EV_TOUT_PRE] |
                               (chg_q == CHG_PRE && chg_d == CHG_FAULT);
    irq_stat_d[EV_TOUT_FULL] = irq_stat_d[EV_TOUT_FULL] |
                               (chg_q == CHG_FULL && chg_d == CHG_FAULT);
    irq_stat_d[EV_EOC]       = irq_stat_d[EV_EOC] | (chg_q == CHG_FULL && chg_d == CHG_DONE);
    irq_stat_d[EV_ADAPTER]   = irq_stat_d[EV_ADAPTER] | (adapter_ok && !adapter_ok_q);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt_q    <= '0;
      dg_cnt_q      <= '{default: '0};
      pwr_q         <= PWR_OFF;
      chg_q         <= CHG_IDLE;
      trig_q        <= '0;
      rel_cnt_q     <= '0;
      chg_tmr_q     <= '0;
      adapter_ok_q  <= 1'b0;
      adapter_pin_q <= 1'b0;
      chg_ctrl_q    <= CHG_CTRL_RST;
      ichg_q        <= ICHG_RST;
      hold_sel_q    <= 1'b0;
      irq_stat_q    <= '0;
      irq_mask_q    <= '0;
      dph_wr_q      <= 1'b0;
      dph_addr_q    <= '0;
      hrdata        <= 32'h0000_0000;
    end else if (ce) begin
      tick_cnt_q    <= tick_cnt_d;
      dg_cnt_q      <= dg_cnt_d;
      pwr_q         <= pwr_d;
      chg_q         <= chg_d;
      trig_q        <= trig_d;
      rel_cnt_q     <= rel_cnt_d;
      chg_tmr_q     <= chg_tmr_d;
      adapter_ok_q  <= adapter_ok_d;
      adapter_pin_q <= pin_q[PIN_ADAPTER];
      chg_ctrl_q    <= chg_ctrl_d;
      ichg_q        <= ichg_d;
      hold_sel_q    <= hold_sel_d;
      irq_stat_q    <= irq_stat_d;
      irq_mask_q    <= irq_mask_d;
      dph_wr_q      <= dph_wr_d;
      dph_addr_q    <= dph_addr_d;
      hrdata        <= rd_d;
    end
  end

  always_comb begin
    hreadyout       = 1'b1;
    hresp           = 1'b0;
    regulator_three = (pwr_q == PWR_UP) || (pwr_q == POWER_KEY_INPUT) || (pwr_q == PWR_RELEASE);
    // Raw pin on purpose: the echo must follow the key with no debounce
    power_key_echo_n = regulator_three ? ~power_key_input : 1'b1;
    charge_enable   = (chg_q == CHG_PRE) || (chg_q == CHG_FULL);
    fullrate_mode   = (chg_q == CHG_FULL);
    irq             = |(irq_stat_q & irq_mask_q);
  end

endmodule // pmu_seq
`default_nettype wire

// ===== pmu_seq_checker.sv
// Concurrent checks on the power sequencer pins.
// Assumes one clock domain; bound into every pmu_seq instance.
`timescale 1ns/1ps
`default_nettype none
module pmu_seq_checker
  import pmu_seq_pkg::*;
#(
  parameter int TICK_CYC = pmu_seq_pkg::TICK_CYCLES,
  parameter int MS_HOUR  = pmu_seq_pkg::MS_PER_HOUR
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic power_key_input,
  input wire logic handsfree_wake_input,
  input wire logic adapter_detect_input,
  input wire logic power_hold_input,
  input wire logic overtemp_input,
  input wire logic prequal_ok_input,
  input wire logic power_key_echo_n,
  input wire logic regulator_three,
  input wire logic charge_enable,
  input wire logic fullrate_mode
);
  logic [15:0] adp_q, adp_d, pq_q, pq_d, hl_q, hl_d;
  logic        held_q, held_d, hot_q, hot_d;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Adapter and qualification run lengths saturate so long charges cannot wrap to a small count
  always_comb begin
    adp_d  = !adapter_detect_input ? 16'h0000 : (&adp_q ? adp_q : adp_q + 16'h0001);
    pq_d   = !prequal_ok_input ? 16'h0000 : (&pq_q ? pq_q : pq_q + 16'h0001);
    hl_d   = (!held_q || power_hold_input || !regulator_three) ? 16'h0000 : hl_q + 16'h0001;
    held_d = regulator_three && (held_q || power_hold_input);
    hot_d  = regulator_three && (hot_q || overtemp_input);
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      adp_q  <= 16'h0000;
      pq_q   <= 16'h0000;
      hl_q   <= 16'h0000;
      held_q <= 1'b0;
      hot_q  <= 1'b0;
    end else begin
      adp_q  <= adp_d;
      pq_q   <= pq_d;
      hl_q   <= hl_d;
      held_q <= held_d;
      hot_q  <= hot_d;
    end
  end
  AST_ECHO: assert property (power_key_echo_n == (regulator_three ? !power_key_input : 1'b1))
    else $error("key echo does not follow key");
  AST_ADP_DG: assert property ($rose(charge_enable) |-> int'(adp_q) >= (ADAPTER_DG_MS - 1) * TICK_CYC)
    else $error("charging began before adapter settled");
  AST_PQ_DG: assert property ($rose(fullrate_mode) && $past(charge_enable)
    |-> int'(pq_q) >= (PREQUAL_DG_MS - 1) * TICK_CYC)
    else $error("full rate began before qualification settled");
  AST_HOLD_DLY: assert property ($fell(regulator_three) && held_q && !hot_q
    |-> int'(hl_q) >= (HOLD_SHORT_MS - 1) * TICK_CYC)
    else $error("power-down came too soon after hold release");
  AST_HOLD_KEEP: assert property ((regulator_three && power_hold_input && !overtemp_input) [*6]
    |=> regulator_three)
    else $error("powered down while hold asserted");
  AST_HOT: assert property ($rose(overtemp_input) && regulator_three |-> ##[1:8] !regulator_three)
    else $error("no power-down on over-temperature");
  AST_KEY_LVL: assert property ($rose(power_key_input) && !regulator_three && !overtemp_input
    |-> ##[1:8] regulator_three)
    else $error("key did not start power-up");
  AST_HF_LVL: assert property ($rose(handsfree_wake_input) && !regulator_three && !overtemp_input
    |-> ##[1:8] regulator_three)
    else $error("hands-free did not start power-up");
  AST_ADP_EDGE: assert property ((!regulator_three && adapter_detect_input && !power_key_input
    && !handsfree_wake_input) [*8] |=> !regulator_three)
    else $error("steady adapter level started power-up");
  cover property ($rose(fullrate_mode) && $past(charge_enable));
  cover property ($fell(regulator_three) && held_q && !hot_q);
  cover property ($fell(charge_enable) && !fullrate_mode);
endmodule // pmu_seq_checker

bind pmu_seq pmu_seq_checker #(.TICK_CYC(TICK_CYC), .MS_HOUR(MS_HOUR)) u_chk (
  .hclk(hclk), .hresetn(hresetn), .power_key_input(power_key_input),
  .handsfree_wake_input(handsfree_wake_input), .adapter_detect_input(adapter_detect_input),
  .power_hold_input(power_hold_input), .overtemp_input(overtemp_input),
  .prequal_ok_input(prequal_ok_input), .power_key_echo_n(power_key_echo_n),
  .regulator_three(regulator_three), .charge_enable(charge_enable),
  .fullrate_mode(fullrate_mode)
);
`default_nettype wire

// ===== host_model.sv
// Host processor stand-in driving the hold pin.
// Assumes the bench keeps the wake input active until hold is seen.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       regulator_three,
  input wire logic       release_req,
  input wire logic [7:0] hold_lat,
  output var logic       power_hold_input
);
  logic [7:0] wait_q, wait_d;
  logic       hold_d;
  // Host loses its supply with regulator three, so hold falls with it
  always_comb begin
    wait_d = !regulator_three ? 8'h00 : (&wait_q ? wait_q : wait_q + 8'h01);
    hold_d = regulator_three && !release_req && (wait_q >= hold_lat);
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wait_q           <= 8'h00;
      power_hold_input <= 1'b0;
    end else begin
      wait_q           <= wait_d;
      power_hold_input <= hold_d;
    end
  end
endmodule // host_model
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for the power sequencer and charger timers.
// Assumes short tick and hour parameters; host_model drives hold.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pmu_seq_pkg::*;
  localparam int TC = 4;
  localparam int MH = 100;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize = 3'b010;
  logic        pk = 1'b0, hf = 1'b0, ad = 1'b0, ot = 1'b0, pq = 1'b0, rel = 1'b0;
  logic [10:0] cur = 11'h029;
  logic [12:0] bat = 13'h1068;
  logic [7:0]  lat = 8'h04;
  logic        hready, hreadyout, hresp, echo, reg3, chg, full, irq, hold;
  int          error_cnt = 0, comparisons = 0, cyc = 0;
  assign hready = hreadyout;
  pmu_seq #(.TICK_CYC(TC), .MS_HOUR(MH)) u_dut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .power_key_input(pk), .handsfree_wake_input(hf), .adapter_detect_input(ad),
    .power_hold_input(hold), .overtemp_input(ot), .prequal_ok_input(pq),
    .charge_current_ma(cur), .battery_mv(bat), .power_key_echo_n(echo),
    .regulator_three(reg3), .charge_enable(chg), .fullrate_mode(full), .irq(irq));
  host_model u_host (.hclk(hclk), .hresetn(hresetn), .regulator_three(reg3),
    .release_req(rel), .hold_lat(lat), .power_hold_input(hold));
  initial forever #25 hclk = ~hclk;
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      print_verdict();
    end
  end
  task print_verdict;
    if (error_cnt == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task rng(input int n, input int lo, input int hi);
    comparisons++;
    if (n < lo || n > hi) begin
      error_cnt++;
      $display("ERROR %0t: count %0d outside %0d..%0d", $time, n, lo, hi);
    end
  endtask
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask
  task rd(input logic [7:0] a, output logic [31:0] x);
    ahb(1'b0, a, 32'h0000_0000, x);
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: return reg3;
      1: return chg;
      default: return full;
    endcase
  endfunction
  // Bounded wait; the returned count fails any range check if it runs out
  task wfor(input int s, input logic v, output int n);
    n = 0;
    while (sig(s) !== v && n < 5000) begin
      @(posedge hclk);
      n++;
    end
  endtask
  task t_reset;
    logic [31:0] x;
    chk(32'({reg3, echo, chg, irq}), 32'h0000_0004);
    chk(32'({hreadyout, hresp}), 32'h0000_0002);
    rd(CHG_CTRL_OFS, x); chk(x, 32'h0000_0003);
    rd(CHG_ICHG_OFS, x); chk(x, 32'h0000_0190);
    rd(8'h1C, x); chk(x, 32'h0000_0000);
    wr(ADDR_ID_OFS, 32'h0000_0000);
    rd(ADDR_ID_OFS, x); chk(x, 32'h0000_007E);
    wr(CHG_CTRL_OFS, 32'h0000_0007);
  endtask
  task t_key;
    logic [31:0] x;
    int n;
    pk <= 1'b1;
    wfor(0, 1'b1, n); rng(n, 1, 8);
    chk(32'(echo), 32'h0000_0000);
    repeat (20) @(posedge hclk);
    wr(IRQ_MASK_OFS, 32'h0000_0001);
    pk <= 1'b0;
    repeat (10) @(posedge hclk);
    chk(32'(echo), 32'h0000_0001);
    repeat (20) @(posedge hclk);
    chk(32'(reg3), 32'h0000_0001);
    rd(STATE_OFS, x); chk(32'(x[5:3]), 32'h0000_0004);
    rel <= 1'b1;
    @(posedge hclk);
    wfor(0, 1'b0, n); rng(n, 34 * TC, 37 * TC + 8);
    rel <= 1'b0;
    rd(IRQ_MASK_OFS, x); chk(x, 32'h0000_0000);
    rd(CHG_CTRL_OFS, x); chk(x, 32'h0000_0007);
  endtask
  task t_hf;
    logic [31:0] x;
    int n;
    wr(MISC_CTRL_OFS, 32'h0000_0001);
    lat <= 8'h3C;
    hf <= 1'b1;
    wfor(0, 1'b1, n); rng(n, 1, 8);
    repeat (80) @(posedge hclk);
    hf <= 1'b0;
    rel <= 1'b1;
    @(posedge hclk);
    wfor(0, 1'b0, n); rng(n, 349 * TC, 352 * TC + 8);
    rel <= 1'b0;
    rd(MISC_CTRL_OFS, x); chk(x, 32'h0000_0000);
  endtask
  task t_adapter;
    int n;
    lat <= 8'h04;
    ad <= 1'b1;
    wfor(1, 1'b1, n); rng(n, 29 * TC, 33 * TC + 8);
    chk(32'(irq), 32'h0000_0000);
    rel <= 1'b1;
    wfor(0, 1'b0, n);
    rel <= 1'b0;
    repeat (40) @(posedge hclk);
    chk(32'(reg3), 32'h0000_0000);
    wr(IRQ_MASK_OFS, 32'h0000_0008);
    pq <= 1'b1;
    repeat (400) @(posedge hclk);
    pq <= 1'b0;
    @(posedge hclk);
    pq <= 1'b1;
    wfor(2, 1'b1, n); rng(n, 209 * TC, 212 * TC + 8);
    repeat (100) @(posedge hclk);
    chk(32'(full), 32'h0000_0001);
    cur <= 11'h028;
    wfor(2, 1'b0, n); rng(n, 209 * TC, 212 * TC + 8);
    repeat (2) @(posedge hclk);
    chk(32'(irq), 32'h0000_0001);
    wr(IRQ_STAT_OFS, 32'h0000_0008);
    repeat (2) @(posedge hclk);
    chk(32'(irq), 32'h0000_0000);
    bat <= 13'h1005;
    repeat (20) @(posedge hclk);
    chk(32'(chg), 32'h0000_0000);
    bat <= 13'h1004;
    wfor(1, 1'b1, n); rng(n, 1, 8);
  endtask
  task t_timers;
    logic [31:0] ctl [4] = '{32'h0000_0001, 32'h0000_0009, 32'h0000_0011, 32'h0000_0021};
    int hrs [4] = '{5, 8, 1, 2};
    logic [31:0] x;
    int n;
    for (int i = 0; i < 4; i++) begin
      pq <= (i < 2);
      wr(CHG_CTRL_OFS, 32'h0000_0000);
      wr(CHG_CTRL_OFS, ctl[i]);
      wfor((i < 2) ? 2 : 1, 1'b1, n);
      wfor(1, 1'b0, n); rng(n, (hrs[i] * MH - 1) * TC, (hrs[i] * MH + 1) * TC + 8);
      rd(IRQ_STAT_OFS, x); chk(32'(x[(i < 2) ? 2 : 1]), 32'h0000_0001);
      wr(IRQ_STAT_OFS, 32'h0000_0006);
    end
  endtask
  task t_hot;
    logic [31:0] x;
    int n;
    pk <= 1'b1;
    wfor(0, 1'b1, n);
    repeat (20) @(posedge hclk);
    pk <= 1'b0;
    repeat (10) @(posedge hclk);
    ot <= 1'b1;
    wfor(0, 1'b0, n); rng(n, 1, 8);
    rd(IRQ_STAT_OFS, x); chk(32'(x[EV_OVERTEMP]), 32'h0000_0001);
    ot <= 1'b0;
  endtask
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_key();
    t_hf();
    t_adapter();
    t_timers();
    t_hot();
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
